// File: dmc_defs.vh
`ifndef DMC_DEFS_VH
`define DMC_DEFS_VH
// ==========================================================
// timing
`define DMC_CLK_PERIOD_NS 4
`define DMC_TICK_NS 1000000
`define DMC_TICK_CYC 18'd250000
`define DMC_TICK_MS 1
`define DMC_EXT_PULSE_MS 100
`define DMC_EXT_PULSE_TICKS 17'd100
`define DMC_HOLD_S 2
`define DMC_HOLD_TICKS 17'd2000
`define DMC_DEGAS_MAX_MIN 2
`define DMC_DEGAS_MAX_TICKS 17'd120000
`define DMC_COOL_MIN 1
`define DMC_COOL_TICKS 17'd60000
// ==========================================================
// register indices
`define DMC_REG_STATUS 2'h0
`define DMC_REG_MASK 2'h1
`define DMC_REG_STATE 2'h2
`define DMC_REG_CMD 2'h3
// ==========================================================
// status / mask bits
`define DMC_EV_DEGAS_END 0
`define DMC_EV_DEGAS_REFUSED 1
`define DMC_EV_MEAS_STOP 2
`define DMC_EV_ALARM 3
`define DMC_EV_SENSOR_ERR 4
`define DMC_EV_WARNING 5
`define DMC_EV_W 6
// ==========================================================
// command bits
`define DMC_CMD_DEGAS_START 0
`define DMC_CMD_DEGAS_STOP 1
`define DMC_CMD_MEAS_START 2
`define DMC_CMD_MEAS_STOP 3
// ==========================================================
// display codes
`define DMC_DISP_PRESSURE 2'h0
`define DMC_DISP_DASHES 2'h1
`define DMC_DISP_COOLING 2'h2
`define DMC_DISP_E100 2'h3
// ==========================================================
// degas states
`define DMC_DG_IDLE 2'h0
`define DMC_DG_RUN 2'h1
`define DMC_DG_COOL 2'h2
`endif

// File: dmc_ctrl.v
// Notes on behaviour
// - degas may start only while the BA gauge is measuring
// - one-minute cooling interval after every degas run
// - start during cooling is refused and shows the cooling indication
// - each qualifying external degas pulse of 100 ms toggles degas
// - degas stops by itself two minutes after it started
// - serial start and stop degas commands act like other sources
// - remote degas button toggles degas only after two seconds held
// - measurement stops on measure control off or serial end command
// - emission button held over two seconds stops measurement
// - stopped measurement: status indicator off, four dashes shown
// - alarm flashes red indicator and halts measurement
// - a measurement start after a passed sensor check clears the alarm and starts measuring
// - latched sensor error rejects every measurement start
// - after power-up the sensor connection and type are checked
// - failed sensor check shows code 100, red flash, until reset
// - warning flashes yellow and sets its status event bit, nothing else
//
// Design decisions made here: the address map and the strobed register port.
`include "dmc_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module dmc_ctrl #(
	parameter [17:0] TICK_CYC = `DMC_TICK_CYC,
	parameter [16:0] EXT_PULSE_TICKS = `DMC_EXT_PULSE_TICKS,
	parameter [16:0] HOLD_TICKS = `DMC_HOLD_TICKS,
	parameter [16:0] DEGAS_MAX_TICKS = `DMC_DEGAS_MAX_TICKS,
	parameter [16:0] COOL_TICKS = `DMC_COOL_TICKS
) (
	input wire mclk_i,
	input wire sys_rst_i,
	input wire ext_degas_i,
	input wire ext_meas_ctrl_i,
	input wire remote_degas_button_i,
	input wire remote_emission_button_i,
	input wire key_degas_on_i,
	input wire key_degas_off_i,
	input wire key_meas_start_i,
	input wire ser_degas_start_i,
	input wire ser_degas_stop_i,
	input wire ser_meas_start_i,
	input wire ser_meas_end_i,
	input wire gauge_ba_i,
	input wire alarm_i,
	input wire warning_i,
	input wire sensor_check_valid_i,
	input wire [3:0] sensor_check_i,
	input wire [1:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output wire [7:0] reg_rdata_o,
	output wire irq_o,
	output wire degas_on_o,
	output wire meas_on_o,
	output wire status_led_on_o,
	output wire alarm_red_flash_o,
	output wire alarm_yellow_flash_o,
	output wire [1:0] disp_code_o
);

	// ==========================================================
	// pin synchronisers
	wire [3:0] pin_raw;
	reg [3:0] pin_meta_ff;
	reg [3:0] pin_sync_ff;
	reg [3:0] pin_prev_ff;
	assign pin_raw = {remote_emission_button_i, remote_degas_button_i,
		ext_meas_ctrl_i, ext_degas_i};

	always @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			pin_meta_ff <= 4'h0;
			pin_sync_ff <= 4'h0;
			pin_prev_ff <= 4'h0;
		end
		else
		begin
			pin_meta_ff <= pin_raw;
			pin_sync_ff <= pin_meta_ff;
			pin_prev_ff <= pin_sync_ff;
		end
	end

	wire meas_ctrl_rise = pin_sync_ff[1] & ~pin_prev_ff[1];
	wire meas_ctrl_fall = ~pin_sync_ff[1] & pin_prev_ff[1];

	// ==========================================================
	// millisecond tick
	reg [17:0] tick_cnt_ff;
	reg tick_ff;

	always @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			tick_cnt_ff <= 18'h0;
			tick_ff <= 1'b0;
		end
		else if (tick_cnt_ff == TICK_CYC - 18'h1)
		begin
			tick_cnt_ff <= 18'h0;
			tick_ff <= 1'b1;
		end
		else
		begin
			tick_cnt_ff <= tick_cnt_ff + 18'h1;
			tick_ff <= 1'b0;
		end
	end

	// ==========================================================
	// press width qualifiers: ext degas, remote degas, emission
	wire [16:0] qual_thr [0:2];
	wire [2:0] qual_lvl;
	wire [2:0] qual_fire;
	assign qual_thr[0] = EXT_PULSE_TICKS;
	assign qual_thr[1] = HOLD_TICKS;
	assign qual_thr[2] = HOLD_TICKS + 17'h1;
	assign qual_lvl = {pin_sync_ff[3], pin_sync_ff[2], pin_sync_ff[0]};

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : g_qual
			reg [16:0] cnt_ff;
			// counter restarts whenever the input drops
			always @(posedge mclk_i)
			begin
				if (sys_rst_i || !qual_lvl[g])
					cnt_ff <= 17'h0;
				else if (tick_ff && cnt_ff != qual_thr[g])
					cnt_ff <= cnt_ff + 17'h1;
			end
			assign qual_fire[g] = qual_lvl[g] & tick_ff &
				(cnt_ff == qual_thr[g] - 17'h1);
		end
	endgenerate

	// ==========================================================
	// register bus commands
	wire wr_cmd = reg_wr_i & (reg_addr_i == `DMC_REG_CMD);
	wire cmd_dg_start = wr_cmd & reg_wdata_i[`DMC_CMD_DEGAS_START];
	wire cmd_dg_stop = wr_cmd & reg_wdata_i[`DMC_CMD_DEGAS_STOP];
	wire cmd_ms_start = wr_cmd & reg_wdata_i[`DMC_CMD_MEAS_START];
	wire cmd_ms_stop = wr_cmd & reg_wdata_i[`DMC_CMD_MEAS_STOP];

	// ==========================================================
	// sensor check and measurement state
	reg chk_done_ff;
	reg sensor_err_ff;
	reg meas_on_ff;
	reg alarm_ff;
	wire chk_now = ~chk_done_ff & sensor_check_valid_i;
	wire chk_pass = (sensor_check_i == 4'hf);
	wire ms_start_req = key_meas_start_i | ser_meas_start_i | cmd_ms_start |
		meas_ctrl_rise | (qual_fire[2] & ~meas_on_ff);
	wire ms_start_ok = ms_start_req & chk_done_ff & ~sensor_err_ff;
	wire ms_stop_req = meas_ctrl_fall | ser_meas_end_i | cmd_ms_stop |
		(qual_fire[2] & meas_on_ff);
	wire alarm_hit = alarm_i & meas_on_ff;

	always @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			chk_done_ff <= 1'b0;
			sensor_err_ff <= 1'b0;
			meas_on_ff <= 1'b0;
			alarm_ff <= 1'b0;
		end
		else
		begin
			if (chk_now)
			begin
				// connected, oriented, combination, filament intact
				chk_done_ff <= 1'b1;
				sensor_err_ff <= ~chk_pass; // held until reset
			end
			if (chk_now && chk_pass)
				meas_on_ff <= 1'b1;
			else if (alarm_hit || ms_stop_req)
				meas_on_ff <= 1'b0;
			else if (ms_start_ok)
				meas_on_ff <= 1'b1;
			if (alarm_hit)
				alarm_ff <= 1'b1;
			else if (ms_start_ok)
				alarm_ff <= 1'b0;
		end
	end

	// ==========================================================
	// degas sequencer
	reg [1:0] dg_state_ff;
	reg [1:0] nxt_dg_state;
	reg [16:0] dg_cnt_ff;
	reg [16:0] nxt_dg_cnt;
	reg cool_ind_ff;
	reg nxt_cool_ind;
	reg dg_end;
	reg dg_refused;
	wire ba_active = gauge_ba_i & meas_on_ff;
	wire dg_toggle = qual_fire[0] | qual_fire[1];
	wire dg_start = key_degas_on_i | ser_degas_start_i | cmd_dg_start;
	wire dg_stop = key_degas_off_i | ser_degas_stop_i | cmd_dg_stop;

	always @*
	begin
		nxt_dg_state = dg_state_ff;
		nxt_dg_cnt = dg_cnt_ff;
		nxt_cool_ind = cool_ind_ff;
		dg_end = 1'b0;
		dg_refused = 1'b0;
		case (dg_state_ff)
			`DMC_DG_IDLE:
			begin
				nxt_cool_ind = 1'b0;
				if (dg_start || dg_toggle)
				begin
					if (ba_active)
					begin
						nxt_dg_state = `DMC_DG_RUN;
						nxt_dg_cnt = 17'h0;
					end
					else
						dg_refused = 1'b1;
				end
			end
			`DMC_DG_RUN:
			begin
				if (dg_stop || dg_toggle || !ba_active ||
					(tick_ff && dg_cnt_ff == DEGAS_MAX_TICKS - 17'h1))
				begin
					// stop, toggle, gauge change or timeout
					nxt_dg_state = `DMC_DG_COOL;
					nxt_dg_cnt = 17'h0;
					dg_end = 1'b1;
				end
				else if (tick_ff)
					nxt_dg_cnt = dg_cnt_ff + 17'h1;
			end
			`DMC_DG_COOL:
			begin
				if (dg_start || dg_toggle)
				begin
					dg_refused = 1'b1;
					nxt_cool_ind = 1'b1;
				end
				if (tick_ff && dg_cnt_ff == COOL_TICKS - 17'h1)
				begin
					nxt_dg_state = `DMC_DG_IDLE;
					nxt_cool_ind = 1'b0;
				end
				else if (tick_ff)
					nxt_dg_cnt = dg_cnt_ff + 17'h1;
			end
			default:
			begin
				nxt_dg_state = `DMC_DG_IDLE;
				nxt_cool_ind = 1'b0;
			end
		endcase
	end

	reg degas_on_ff;

	always @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			dg_state_ff <= `DMC_DG_IDLE;
			dg_cnt_ff <= 17'h0;
			cool_ind_ff <= 1'b0;
			degas_on_ff <= 1'b0;
		end
		else
		begin
			dg_state_ff <= nxt_dg_state;
			dg_cnt_ff <= nxt_dg_cnt;
			cool_ind_ff <= nxt_cool_ind;
			degas_on_ff <= (nxt_dg_state == `DMC_DG_RUN);
		end
	end

	// ==========================================================
	// indicators and display
	reg status_led_ff;
	reg red_ff;
	reg yellow_ff;
	reg [1:0] disp_ff;
	reg [1:0] nxt_disp;

	always @*
	begin
		if (sensor_err_ff)
			nxt_disp = `DMC_DISP_E100;
		else if (nxt_cool_ind)
			nxt_disp = `DMC_DISP_COOLING;
		else if (!meas_on_ff)
			nxt_disp = `DMC_DISP_DASHES;
		else
			nxt_disp = `DMC_DISP_PRESSURE;
	end

	always @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			status_led_ff <= 1'b0;
			red_ff <= 1'b0;
			yellow_ff <= 1'b0;
			disp_ff <= `DMC_DISP_DASHES;
		end
		else
		begin
			status_led_ff <= meas_on_ff;
			red_ff <= alarm_ff | sensor_err_ff;
			yellow_ff <= warning_i; // only an indication
			disp_ff <= nxt_disp;
		end
	end

	// ==========================================================
	// event status, mask, interrupt, read port
	reg [`DMC_EV_W-1:0] ev_status_ff;
	reg [`DMC_EV_W-1:0] ev_mask_ff;
	reg warn_prev_ff;
	reg irq_ff;
	reg [7:0] rdata_ff;
	reg [7:0] nxt_rdata;
	wire [`DMC_EV_W-1:0] ev_set;
	wire [`DMC_EV_W-1:0] ev_clr;
	wire [`DMC_EV_W-1:0] nxt_status;
	assign ev_set[`DMC_EV_DEGAS_END] = dg_end;
	assign ev_set[`DMC_EV_DEGAS_REFUSED] = dg_refused;
	assign ev_set[`DMC_EV_MEAS_STOP] = meas_on_ff & (alarm_hit | ms_stop_req);
	assign ev_set[`DMC_EV_ALARM] = alarm_hit;
	assign ev_set[`DMC_EV_SENSOR_ERR] = chk_now & ~chk_pass;
	assign ev_set[`DMC_EV_WARNING] = warning_i & ~warn_prev_ff;
	assign ev_clr = (reg_wr_i && reg_addr_i == `DMC_REG_STATUS) ?
		reg_wdata_i[`DMC_EV_W-1:0] : {`DMC_EV_W{1'b0}};
	// set wins over a same-cycle clear
	assign nxt_status = (ev_status_ff & ~ev_clr) | ev_set;

	always @*
	begin
		nxt_rdata = 8'h00;
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				`DMC_REG_STATUS: nxt_rdata = {2'h0, ev_status_ff};
				`DMC_REG_MASK: nxt_rdata = {2'h0, ev_mask_ff};
				`DMC_REG_STATE: nxt_rdata = {red_ff, sensor_err_ff,
					alarm_ff, meas_on_ff, cool_ind_ff, chk_done_ff,
					dg_state_ff};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			ev_status_ff <= {`DMC_EV_W{1'b0}};
			ev_mask_ff <= {`DMC_EV_W{1'b0}};
			warn_prev_ff <= 1'b0;
			irq_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end
		else
		begin
			ev_status_ff <= nxt_status;
			if (reg_wr_i && reg_addr_i == `DMC_REG_MASK)
				ev_mask_ff <= reg_wdata_i[`DMC_EV_W-1:0];
			warn_prev_ff <= warning_i;
			irq_ff <= |(nxt_status & ev_mask_ff);
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign irq_o = irq_ff;
	assign degas_on_o = degas_on_ff;
	assign meas_on_o = meas_on_ff;
	assign status_led_on_o = status_led_ff;
	assign alarm_red_flash_o = red_ff;
	assign alarm_yellow_flash_o = yellow_ff;
	assign disp_code_o = disp_ff;

endmodule // dmc_ctrl
`default_nettype wire

// File: dmc_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dmc_ctrl_chk #(
	parameter int TICK_CYC = 4,
	parameter int DEGAS_MAX_TICKS = 20
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic gauge_ba_i,
	input wire logic alarm_i,
	input wire logic warning_i,
	input wire logic degas_on_o,
	input wire logic meas_on_o,
	input wire logic status_led_on_o,
	input wire logic alarm_yellow_flash_o,
	input wire logic [1:0] disp_code_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	// ==========================================================
	// length of the current degas run in cycles
	int run_ff;
	always_ff @(posedge mclk_i)
		if (sys_rst_i || !degas_on_o)
			run_ff <= 0;
		else
			run_ff <= run_ff + 1;
	// ==========================================================
	// assertions
	deg_needs_ba_a: assert property ($rose(degas_on_o) |-> $past(gauge_ba_i))
		else $error("degas started without ba gauge");
	deg_limit_a: assert property (run_ff <= (DEGAS_MAX_TICKS + 1) * TICK_CYC + 2)
		else $error("degas ran past its limit");
	deg_ba_loss_a: assert property ((degas_on_o && !gauge_ba_i) |=> !degas_on_o)
		else $error("degas kept on after ba loss");
	cool_hold_a: assert property ($fell(degas_on_o) |=> !degas_on_o [*8])
		else $error("degas restarted while cooling");
	led_follow_a: assert property (1 |=> status_led_on_o == $past(meas_on_o))
		else $error("status indicator off track");
	stop_dash_a: assert property (!meas_on_o [*2] |-> disp_code_o != 2'h0)
		else $error("pressure shown while stopped");
	yellow_warn_a: assert property (1 |=> alarm_yellow_flash_o == $past(warning_i))
		else $error("yellow flash off track");
	alarm_halt_a: assert property ((alarm_i && meas_on_o) |=> !meas_on_o)
		else $error("alarm did not halt measurement");
	err_no_meas_a: assert property ((disp_code_o == 2'h3) |-> !meas_on_o)
		else $error("measuring with sensor error");
	cover property ($fell(degas_on_o));
	cover property (disp_code_o == 2'h2);
	cover property (alarm_i && meas_on_o);
endmodule // dmc_ctrl_chk
`default_nettype wire

// File: dmc_partner.sv
`timescale 1ns/10ps
`default_nettype none
module dmc_partner (
	input wire logic mclk_i,
	input wire logic go_i,
	input wire logic [1:0] sel_i,
	input wire logic [7:0] len_i,
	output logic [2:0] pin_o
);
	logic [7:0] cnt_ff = 8'h0;
	logic [1:0] sel_ff = 2'h0;
	always @(posedge mclk_i)
	begin
		if (go_i)
			sel_ff <= sel_i;
		cnt_ff <= go_i ? len_i : cnt_ff - {7'h0, cnt_ff != 8'h0};
	end
	// pulse or button held for the asked length, then released low
	assign pin_o = (cnt_ff != 8'h0) ? (3'h1 << sel_ff) : 3'h0;
endmodule // dmc_partner
`default_nettype wire

// File: tb_dmc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_dmc_ctrl;
	typedef struct {int b; logic [7:0] e; int w;} dmc_row_t;
	localparam logic [7:0] DG = 8'h04, MS = 8'h08, IRQ = 8'h10;
	localparam logic [7:0] LED = 8'h20, RED = 8'h40, YEL = 8'h80;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [6:0] pul = 7'h0;
	logic emc = 1'b0, ba = 1'b1, alm = 1'b0, wrn = 1'b0, go = 1'b0;
	logic scv = 1'b0;
	logic [3:0] sc = 4'hf;
	logic [1:0] ra = 2'h0, sel = 2'h0;
	logic [7:0] wd = 8'h0, len = 8'h0;
	logic wr = 1'b0, rd = 1'b0;
	wire [7:0] rdat;
	wire [2:0] pin;
	wire irq, dg, ms, led, red, yel;
	wire [1:0] disp;
	wire [7:0] st = {yel, red, led, irq, ms, dg, disp};
	int error_cnt = 0, total_checks = 0;
	dmc_row_t rows[8] = '{'{3, 8'h0c, 0}, '{4, 8'h08, 50}, '{0, 8'h0c, 0},
		'{1, 8'h08, 50}, '{6, 8'h00, 0}, '{0, 8'h00, 0}, '{2, 8'h08, 0},
		'{5, 8'h08, 0}};
	dmc_ctrl #(.TICK_CYC(18'd4), .EXT_PULSE_TICKS(17'd3), .HOLD_TICKS(17'd5),
		.DEGAS_MAX_TICKS(17'd20), .COOL_TICKS(17'd10)) dmc_ctrl_i (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ext_degas_i(pin[0]),
		.ext_meas_ctrl_i(emc), .remote_degas_button_i(pin[1]),
		.remote_emission_button_i(pin[2]), .key_degas_on_i(pul[0]),
		.key_degas_off_i(pul[1]), .key_meas_start_i(pul[2]),
		.ser_degas_start_i(pul[3]), .ser_degas_stop_i(pul[4]),
		.ser_meas_start_i(pul[5]), .ser_meas_end_i(pul[6]),
		.gauge_ba_i(ba), .alarm_i(alm), .warning_i(wrn),
		.sensor_check_valid_i(scv), .sensor_check_i(sc), .reg_addr_i(ra),
		.reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
		.irq_o(irq), .degas_on_o(dg), .meas_on_o(ms), .status_led_on_o(led),
		.alarm_red_flash_o(red), .alarm_yellow_flash_o(yel),
		.disp_code_o(disp));
	dmc_partner dmc_partner_i (.mclk_i(mclk_i), .go_i(go), .sel_i(sel),
		.len_i(len), .pin_o(pin));
	initial
		forever #2 mclk_i = ~mclk_i;
	// ==========================================================
	// tasks
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic pls(input int b);
		@(posedge mclk_i) pul <= 7'h1 << b;
		@(posedge mclk_i) pul <= 7'h0;
		cyc(2);
	endtask
	task automatic wrr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk_i)
		begin
			ra <= a;
			wd <= d;
			wr <= 1'b1;
		end
		@(posedge mclk_i) wr <= 1'b0;
	endtask
	task automatic rdr(input logic [1:0] a, input logic [7:0] e);
		@(posedge mclk_i)
		begin
			ra <= a;
			rd <= 1'b1;
		end
		@(posedge mclk_i) rd <= 1'b0;
		#1 chk(rdat, e);
	endtask
	task automatic hold(input logic [1:0] s, input logic [7:0] n,
		input logic [7:0] e);
		@(posedge mclk_i)
		begin
			sel <= s;
			len <= n;
			go <= 1'b1;
		end
		@(posedge mclk_i) go <= 1'b0;
		cyc(n + 12);
		chk(st & (DG | MS), e);
	endtask
	// ==========================================================
	// watchdog
	initial
	begin
		repeat (20000) @(posedge mclk_i);
		error_cnt++;
		complete_run;
	end
	// ==========================================================
	// main sequence
	initial
	begin
		cyc(3);
		chk(st, 8'h01);
		@(posedge mclk_i) sys_rst_i <= 1'b0;
		cyc(4);
		chk(st & (MS | LED | 8'h03), 8'h01);
		pls(2);
		chk(st & MS, 8'h00);
		@(posedge mclk_i) scv <= 1'b1;
		cyc(4);
		chk(st & (MS | LED | 8'h03), 8'h28);
		$display("reset done");
		foreach (rows[k])
		begin
			pls(rows[k].b);
			chk(st & (DG | MS), rows[k].e);
			cyc(rows[k].w);
		end
		$display("table done");
		wrr(2'h3, 8'h08);
		cyc(2);
		chk(st & (DG | MS), 8'h00);
		wrr(2'h3, 8'h04);
		cyc(2);
		chk(st & (DG | MS), MS);
		wrr(2'h3, 8'h01);
		cyc(2);
		chk(st & (DG | MS), DG | MS);
		wrr(2'h3, 8'h02);
		cyc(2);
		chk(st & (DG | MS), MS);
		cyc(50);
		$display("command register done");
		wrr(2'h0, 8'h3f);
		wrr(2'h1, 8'h01);
		rdr(2'h1, 8'h01);
		pls(3);
		cyc(70);
		chk(st & DG, DG);
		cyc(20);
		chk(st & (DG | IRQ), IRQ);
		pls(0);
		chk(st & (DG | 8'h03), 8'h02);
		rdr(2'h0, 8'h03);
		rdr(2'h3, 8'h00);
		wrr(2'h1, 8'h00);
		cyc(2);
		chk(st & IRQ, 8'h00);
		wrr(2'h0, 8'h03);
		rdr(2'h0, 8'h00);
		cyc(50);
		pls(0);
		chk(st & (DG | 8'h03), DG);
		pls(1);
		cyc(50);
		$display("degas timing done");
		for (int s = 0; s < 2; s++)
		begin
			hold(s[1:0], 8'd4, MS);
			hold(s[1:0], 8'd40, DG | MS);
			hold(s[1:0], 8'd40, MS);
			cyc(50);
		end
		$display("pulse toggles done");
		hold(2'h2, 8'd40, 8'h00);
		chk(st & (LED | 8'h03), 8'h01);
		hold(2'h2, 8'd8, 8'h00);
		hold(2'h2, 8'd40, MS);
		@(posedge mclk_i) emc <= 1'b1;
		cyc(6);
		@(posedge mclk_i) emc <= 1'b0;
		cyc(6);
		chk(st & MS, 8'h00);
		pls(2);
		$display("measure stop done");
		@(posedge mclk_i) alm <= 1'b1;
		@(posedge mclk_i) alm <= 1'b0;
		cyc(2);
		chk(st & (MS | RED), RED);
		pls(5);
		cyc(1);
		chk(st & (MS | RED), MS);
		@(posedge mclk_i) wrn <= 1'b1;
		cyc(3);
		chk(st & (MS | YEL), MS | YEL);
		@(posedge mclk_i) wrn <= 1'b0;
		$display("alarm and warning done");
		pls(3);
		@(posedge mclk_i) ba <= 1'b0;
		cyc(2);
		chk(st & DG, 8'h00);
		@(posedge mclk_i) ba <= 1'b1;
		pls(3);
		chk(st & DG, 8'h00);
		$display("gauge loss done");
		@(posedge mclk_i)
		begin
			sys_rst_i <= 1'b1;
			sc <= 4'h7;
		end
		cyc(2);
		@(posedge mclk_i) sys_rst_i <= 1'b0;
		cyc(4);
		chk(st & (RED | 8'h03), RED | 8'h03);
		pls(5);
		chk(st & MS, 8'h00);
		rdr(2'h2, 8'hc4);
		$display("sensor error done");
		complete_run;
	end
endmodule // tb_dmc_ctrl
bind dmc_ctrl dmc_ctrl_chk #(.TICK_CYC(TICK_CYC),
	.DEGAS_MAX_TICKS(DEGAS_MAX_TICKS)) dmc_ctrl_chk_i (
	.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .gauge_ba_i(gauge_ba_i),
	.alarm_i(alarm_i), .warning_i(warning_i), .degas_on_o(degas_on_o),
	.meas_on_o(meas_on_o), .status_led_on_o(status_led_on_o),
	.alarm_yellow_flash_o(alarm_yellow_flash_o), .disp_code_o(disp_code_o));
`default_nettype wire
